// file: inc/acu_pkg.sv
// constants, opcodes and states of the accumulator calculation unit
// assumes one synchronous clock domain; no software-visible registers
// Overview of operation
// - add: accumulator becomes accumulator plus selected register
// - subtract: accumulator becomes accumulator minus selected register
// - and, or, xor: accumulator combined bitwise with selected register
// - absolute value: selected register replaced by its magnitude
// - clear: selected register set to zero
// - copy: accumulator loaded from selected register, register untouched
// - indirect copy: selected register names the source for the accumulator
// - increment and decrement selected register in place
// - signed divide accumulator by low half of register, quotient kept
// - modulo: same division, remainder kept in accumulator
// - high-word load, sign extended into the accumulator
// - low-word load, sign extended into the accumulator
// - signed multiply, product into accumulator
// - unsigned multiply, product into accumulator
// - save: accumulator written into selected register
// - accumulator low half into register high half, low half kept
// - accumulator low half into register low half, high half kept
// - indirect save: selected register names the destination
// - shift left one, zero enters bit 0
// - arithmetic shift right one, bit 31 kept and copied to bit 30
// - logical shift right one, zero enters bit 31
// - subtract selected register from target and actual position
package acu_pkg;

    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int NUM_REGS_DEF = 32;
    localparam int ACC_IDX = 10;
    localparam int TGT_POS_IDX = 0;
    localparam int ACT_POS_IDX = 1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int ITER_CNT = 32;
    localparam int OP_W = 5;

    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_SUB = 5'h01,
        OP_AND = 5'h02,
        OP_OR = 5'h03,
        OP_XOR = 5'h04,
        OP_ABS = 5'h05,
        OP_CLR = 5'h06,
        OP_COPY = 5'h07,
        OP_COPY_IND = 5'h08,
        OP_INC = 5'h09,
        OP_DEC = 5'h0a,
        OP_DIV = 5'h0b,
        OP_MOD = 5'h0c,
        OP_LOAD_HI = 5'h0d,
        OP_LOAD_LO = 5'h0e,
        OP_MUL_S = 5'h0f,
        OP_MUL_U = 5'h10,
        OP_SAVE = 5'h11,
        OP_SAVE_LH = 5'h12,
        OP_SAVE_LL = 5'h13,
        OP_SAVE_IND = 5'h14,
        OP_SHL = 5'h15,
        OP_SHR_A = 5'h16,
        OP_SHR_L = 5'h17,
        OP_POS_SUB = 5'h18
    } acu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_WAIT = 2'b10
    } acu_state_t;

endpackage

// file: logic/acu_div.sv
// signed 32 by 16 restoring divider, quotient and remainder
// assumes a nonzero divisor; the caller screens out division by zero
`timescale 1ns/1ns
`default_nettype none
module acu_div (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    input wire logic [31:0] num_i,
    input wire logic [15:0] den_i,
    output logic done_o,
    output logic [31:0] quot_o,
    output logic [31:0] rem_o
);
    logic [31:0] q_reg;
    logic [16:0] r_reg;
    logic [15:0] d_reg;
    logic q_neg_reg;
    logic r_neg_reg;
    logic [5:0] cnt_reg;
    logic busy_reg;
    logic [16:0] r_sh;
    logic [16:0] r_dif;
    logic [31:0] q_nx;
    logic [16:0] r_nx;

    // one quotient bit per cycle, magnitudes only
    assign r_sh = {r_reg[15:0], q_reg[31]};
    assign r_dif = r_sh - {1'b0, d_reg};
    assign q_nx = {q_reg[30:0], !r_dif[16]};
    assign r_nx = r_dif[16] ? r_sh : r_dif;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_reg <= '0;
            r_reg <= '0;
            d_reg <= '0;
            q_neg_reg <= 1'b0;
            r_neg_reg <= 1'b0;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_o <= 1'b0;
            quot_o <= '0;
            rem_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (go_i) begin
                q_reg <= num_i[31] ? 32'h0 - num_i : num_i;
                d_reg <= den_i[15] ? 16'h0 - den_i : den_i;
                r_reg <= '0;
                q_neg_reg <= num_i[31] ^ den_i[15];
                r_neg_reg <= num_i[31];
                cnt_reg <= '0;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                r_reg <= r_nx;
                q_reg <= q_nx;
                cnt_reg <= cnt_reg + 6'h01;
                // results land together with done, so the caller can write
                // them in the done cycle; truncation toward zero, remainder
                // follows the dividend sign
                if (cnt_reg == 6'(acu_pkg::ITER_CNT - 1)) begin
                    busy_reg <= 1'b0;
                    done_o <= 1'b1;
                    quot_o <= q_neg_reg ? 32'h0 - q_nx : q_nx;
                    rem_o <= r_neg_reg ? 32'h0 - {15'h0, r_nx}
                                       : {15'h0, r_nx};
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/acu_mul.sv
// iterative shift-and-add multiplier keeping the low product word
// operands are latched at go, so they need only be valid in that cycle
`timescale 1ns/1ns
`default_nettype none
module acu_mul #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    output logic done_o,
    output logic [W-1:0] prod_o
);
    logic [W-1:0] mcand_reg;
    logic [W-1:0] mplier_reg;
    logic [5:0] cnt_reg;
    logic busy_reg;

    // low word is the same for signed and unsigned operands, so one
    // datapath serves both multiply flavours
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mcand_reg <= '0;
            mplier_reg <= '0;
            prod_o <= '0;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (go_i) begin
                mcand_reg <= a_i;
                mplier_reg <= b_i;
                prod_o <= '0;
                cnt_reg <= '0;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (mplier_reg[0]) begin
                    prod_o <= prod_o + mcand_reg; // wraps
                end
                mcand_reg <= {mcand_reg[W-2:0], 1'b0};
                mplier_reg <= {1'b0, mplier_reg[W-1:1]};
                cnt_reg <= cnt_reg + 6'h01;
                if (cnt_reg == 6'(acu_pkg::ITER_CNT - 1)) begin
                    busy_reg <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/acu_top.sv
// accumulator calculation unit: register file plus one-operation engine
// assumes the sequencer waits for done before issuing the next command
`timescale 1ns/1ns
`default_nettype none
module acu_top #(
    parameter int NUM_REGS = acu_pkg::NUM_REGS_DEF,
    parameter int IDX_W = $clog2(NUM_REGS)
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic START_I,
    input wire logic [acu_pkg::OP_W-1:0] OP_I,
    input wire logic [IDX_W-1:0] SEL_I,
    input wire logic WR_EN_I,
    input wire logic [IDX_W-1:0] WR_SEL_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic [IDX_W-1:0] RD_SEL_I,
    output logic BUSY_O,
    output logic DONE_O,
    output logic ERR_O,
    output logic [31:0] RD_DATA_O,
    output logic [31:0] ACC_O
);
    localparam logic [IDX_W-1:0] ACC = IDX_W'(acu_pkg::ACC_IDX);
    localparam logic [IDX_W-1:0] TGT = IDX_W'(acu_pkg::TGT_POS_IDX);
    localparam logic [IDX_W-1:0] ACT = IDX_W'(acu_pkg::ACT_POS_IDX);

    logic [31:0] regs [NUM_REGS];
    acu_pkg::acu_state_t state_reg;
    acu_pkg::acu_state_t state_next;
    acu_pkg::acu_op_t op_reg;
    logic [IDX_W-1:0] sel_reg;
    logic [31:0] a_reg;
    logic [31:0] b_reg;
    logic done_reg;
    logic err_reg;

    logic start_ok;
    logic sel_ok;
    logic ext_wr;
    logic ptr_ok;
    logic [IDX_W-1:0] ptr_idx;
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [31:0] wr_data;
    logic pos_en;
    logic fin;
    logic fin_err;
    logic mul_go;
    logic div_go;
    logic mul_done;
    logic div_done;
    logic [31:0] prod;
    logic [31:0] quot;
    logic [31:0] rem;

    // a command is only taken while idle
    assign start_ok = START_I && (state_reg == acu_pkg::ST_IDLE);
    assign sel_ok = 32'(SEL_I) < 32'(NUM_REGS);
    assign BUSY_O = (state_reg != acu_pkg::ST_IDLE);
    assign DONE_O = done_reg;
    assign ERR_O = err_reg;

    // external writes lose to a start in the same cycle and are dropped while busy
    assign ext_wr = WR_EN_I && !START_I && !BUSY_O
                    && (32'(WR_SEL_I) < 32'(NUM_REGS));

    // pointer held in the selected register, checked against the file size
    assign ptr_ok = b_reg < 32'(NUM_REGS);
    assign ptr_idx = b_reg[IDX_W-1:0];

    acu_mul #(
        .W(acu_pkg::WORD_W)
    ) u_mul (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .go_i(mul_go),
        .a_i(a_reg),
        .b_i(b_reg),
        .done_o(mul_done),
        .prod_o(prod)
    );

    acu_div u_div (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .go_i(div_go),
        .num_i(a_reg),
        .den_i(b_reg[acu_pkg::HALF_W-1:0]),
        .done_o(div_done),
        .quot_o(quot),
        .rem_o(rem)
    );

    // operation decode: one write port plus the dual position update
    always_comb begin
        wr_en = 1'b0;
        wr_idx = ACC;
        wr_data = a_reg;
        pos_en = 1'b0;
        fin = 1'b0;
        fin_err = 1'b0;
        mul_go = 1'b0;
        div_go = 1'b0;
        state_next = state_reg;
        unique case (state_reg)
            acu_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_next = acu_pkg::ST_EXEC;
                end
            end
            acu_pkg::ST_EXEC: begin
                fin = 1'b1;
                state_next = acu_pkg::ST_IDLE;
                wr_en = 1'b1;
                unique case (op_reg)
                    acu_pkg::OP_ADD: wr_data = a_reg + b_reg;
                    acu_pkg::OP_SUB: wr_data = a_reg - b_reg;
                    acu_pkg::OP_AND: wr_data = a_reg & b_reg;
                    acu_pkg::OP_OR: wr_data = a_reg | b_reg;
                    acu_pkg::OP_XOR: wr_data = a_reg ^ b_reg;
                    acu_pkg::OP_ABS: begin
                        wr_idx = sel_reg;
                        // most negative value wraps onto itself
                        wr_data = b_reg[31] ? 32'h0 - b_reg : b_reg;
                    end
                    acu_pkg::OP_CLR: begin
                        wr_idx = sel_reg;
                        wr_data = 32'h0000_0000;
                    end
                    acu_pkg::OP_COPY: wr_data = b_reg;
                    acu_pkg::OP_COPY_IND: begin
                        wr_en = ptr_ok;
                        fin_err = !ptr_ok;
                        wr_data = ptr_ok ? regs[ptr_idx] : a_reg;
                    end
                    acu_pkg::OP_INC: begin
                        wr_idx = sel_reg;
                        wr_data = b_reg + 32'h1;
                    end
                    acu_pkg::OP_DEC: begin
                        wr_idx = sel_reg;
                        wr_data = b_reg - 32'h1;
                    end
                    acu_pkg::OP_DIV,
                    acu_pkg::OP_MOD: begin
                        wr_en = 1'b0;
                        // zero divisor ends at once, accumulator untouched
                        if (b_reg[15:0] == 16'h0000) begin
                            fin_err = 1'b1;
                        end else begin
                            fin = 1'b0;
                            div_go = 1'b1;
                            state_next = acu_pkg::ST_WAIT;
                        end
                    end
                    acu_pkg::OP_LOAD_HI:
                        wr_data = {{16{b_reg[31]}}, b_reg[31:16]};
                    acu_pkg::OP_LOAD_LO:
                        wr_data = {{16{b_reg[15]}}, b_reg[15:0]};
                    acu_pkg::OP_MUL_S,
                    acu_pkg::OP_MUL_U: begin
                        wr_en = 1'b0;
                        fin = 1'b0;
                        mul_go = 1'b1;
                        state_next = acu_pkg::ST_WAIT;
                    end
                    acu_pkg::OP_SAVE: begin
                        wr_idx = sel_reg;
                        wr_data = a_reg;
                    end
                    acu_pkg::OP_SAVE_LH: begin
                        wr_idx = sel_reg;
                        wr_data = {a_reg[15:0], b_reg[15:0]};
                    end
                    acu_pkg::OP_SAVE_LL: begin
                        wr_idx = sel_reg;
                        wr_data = {b_reg[31:16], a_reg[15:0]};
                    end
                    acu_pkg::OP_SAVE_IND: begin
                        wr_en = ptr_ok;
                        fin_err = !ptr_ok;
                        wr_idx = ptr_idx;
                        wr_data = a_reg;
                    end
                    acu_pkg::OP_SHL: begin
                        wr_idx = sel_reg;
                        wr_data = {b_reg[30:0], 1'b0};
                    end
                    acu_pkg::OP_SHR_A: begin
                        wr_idx = sel_reg;
                        wr_data = {b_reg[31], b_reg[31:1]};
                    end
                    acu_pkg::OP_SHR_L: begin
                        wr_idx = sel_reg;
                        wr_data = {1'b0, b_reg[31:1]};
                    end
                    acu_pkg::OP_POS_SUB: begin
                        wr_en = 1'b0;
                        pos_en = 1'b1;
                    end
                    default: begin
                        wr_en = 1'b0;
                        fin_err = 1'b1;
                    end
                endcase
            end
            acu_pkg::ST_WAIT: begin
                if (mul_done || div_done) begin
                    fin = 1'b1;
                    wr_en = 1'b1;
                    state_next = acu_pkg::ST_IDLE;
                end
                if (mul_done) begin
                    wr_data = prod;
                end else if (op_reg == acu_pkg::OP_MOD) begin
                    wr_data = rem;
                end else begin
                    wr_data = quot;
                end
            end
            default: begin
                state_next = acu_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencing
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= acu_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // operands latched at start; an out-of-range selection reads zero
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            op_reg <= acu_pkg::OP_ADD;
            sel_reg <= '0;
            a_reg <= '0;
            b_reg <= '0;
        end else if (start_ok) begin
            op_reg <= acu_pkg::acu_op_t'(OP_I);
            sel_reg <= SEL_I;
            a_reg <= regs[ACC];
            b_reg <= sel_ok ? regs[SEL_I] : 32'h0000_0000;
        end
    end

    // register file; the accumulator is simply one of its entries
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= acu_pkg::REG_RESET; // 32-bit words
            end
        end else if (ext_wr) begin
            regs[WR_SEL_I] <= WR_DATA_I;
        end else if (pos_en) begin
            regs[TGT] <= regs[TGT] - b_reg;
            regs[ACT] <= regs[ACT] - b_reg;
        end else if (wr_en && (32'(wr_idx) < 32'(NUM_REGS))) begin
            regs[wr_idx] <= wr_data;
        end
    end

    // completion pulse and error flag, both one cycle wide
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            done_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            done_reg <= fin;
            err_reg <= fin && (fin_err || !(32'(sel_reg) < 32'(NUM_REGS)));
        end
    end

    // observation ports, registered so they never glitch
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RD_DATA_O <= '0;
            ACC_O <= '0;
        end else begin
            RD_DATA_O <= (32'(RD_SEL_I) < 32'(NUM_REGS)) ? regs[RD_SEL_I]
                                                         : 32'h0000_0000;
            ACC_O <= regs[ACC];
        end
    end
endmodule
`default_nettype wire

// file: verification/accumulator_calc_unit_tb.sv
// self-checking bench for the calculation unit with a reference model
// assumes acu_top, its checker and the sequencer model are compiled first
`timescale 1ns/1ns
`default_nettype none
module accumulator_calc_unit_tb;
    localparam int N = 24;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start, done, busy, err, wr_en;
    logic [4:0] op, sel, wr_sel, rd_sel;
    logic [31:0] wr_data, rd_data, acc;
    logic [31:0] m [0:31];
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 94653;
    int cyc = 0;

    always #4 clk = ~clk;

    acu_top #(.NUM_REGS(N)) i_dut (
        .CLK_I(clk), .RST_B_I(rst_b), .START_I(start), .OP_I(op),
        .SEL_I(sel), .WR_EN_I(wr_en), .WR_SEL_I(wr_sel),
        .WR_DATA_I(wr_data), .RD_SEL_I(rd_sel), .BUSY_O(busy),
        .DONE_O(done), .ERR_O(err), .RD_DATA_O(rd_data), .ACC_O(acc)
    );
    acu_seq_model i_seq (.clk_i(clk), .done_i(done), .start_o(start),
        .op_o(op), .sel_o(sel));

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    // kept is low for writes that the unit must drop
    task automatic wr(input logic [4:0] i, input logic [31:0] d, input bit kept);
        wr_en = 1'b1;
        wr_sel = i;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        wr_data = ~d;
        if (kept && i < N) m[i] = d;
        // an idle edge so a following call never retoggles in one step
        @(posedge clk);
        #1;
    endtask

    task automatic check_all();
        for (int i = 0; i < 32; i++) begin
            rd_sel = i[4:0];
            @(posedge clk);
            #1;
            cmp_word(rd_data, m[i]);
        end
    endtask

    // model one command, issue it, compare flag, and accumulator when gap is nonzero
    task automatic run(input logic [4:0] o, input logic [4:0] s, input int gap);
        logic [31:0] v, a, ra, rs;
        logic signed [31:0] sa, sd, q, rm;
        logic ex;
        v = m[s];
        a = m[10];
        ra = a;
        rs = v;
        sa = a;
        sd = $signed(v[15:0]);
        q = 0;
        rm = 0;
        if (sd != 0) q = sa / sd;
        if (sd != 0) rm = sa % sd;
        ex = s >= N || o > 5'h18 || (v >= N && (o == acu_pkg::OP_COPY_IND ||
             o == acu_pkg::OP_SAVE_IND)) || (v[15:0] == 16'h0 &&
             (o == acu_pkg::OP_DIV || o == acu_pkg::OP_MOD));
        case (o)
            acu_pkg::OP_ADD: ra = a + v;
            acu_pkg::OP_SUB: ra = a - v;
            acu_pkg::OP_AND: ra = a & v;
            acu_pkg::OP_OR: ra = a | v;
            acu_pkg::OP_XOR: ra = a ^ v;
            acu_pkg::OP_ABS: rs = v[31] ? -v : v;
            acu_pkg::OP_CLR: rs = 32'h0;
            acu_pkg::OP_COPY: ra = v;
            acu_pkg::OP_COPY_IND: ra = ex ? a : m[v[4:0]];
            acu_pkg::OP_INC: rs = v + 32'h1;
            acu_pkg::OP_DEC: rs = v - 32'h1;
            acu_pkg::OP_DIV: ra = ex ? a : q;
            acu_pkg::OP_MOD: ra = ex ? a : rm;
            acu_pkg::OP_LOAD_HI: ra = {{16{v[31]}}, v[31:16]};
            acu_pkg::OP_LOAD_LO: ra = {{16{v[15]}}, v[15:0]};
            acu_pkg::OP_MUL_S: ra = a * v;
            acu_pkg::OP_MUL_U: ra = a * v;
            acu_pkg::OP_SAVE: rs = a;
            acu_pkg::OP_SAVE_LH: rs = {a[15:0], v[15:0]};
            acu_pkg::OP_SAVE_LL: rs = {v[31:16], a[15:0]};
            acu_pkg::OP_SHL: rs = {v[30:0], 1'b0};
            acu_pkg::OP_SHR_A: rs = {v[31], v[31:1]};
            acu_pkg::OP_SHR_L: rs = {1'b0, v[31:1]};
            default: ra = a;
        endcase
        // an unchanged accumulator lets the register write through
        if (ra !== a) m[10] = ra;
        else if (!ex) m[s] = rs;
        if (o == acu_pkg::OP_SAVE_IND && !ex) m[v[4:0]] = a;
        if (o == acu_pkg::OP_POS_SUB) m[0] = m[0] - v;
        if (o == acu_pkg::OP_POS_SUB) m[1] = m[1] - v;
        i_seq.issue(o, s, gap);
        cmp_flag(err, ex);
        if (gap > 0) begin
            @(posedge clk);
            #1;
            cmp_word(acc, m[10]);
        end
    endtask

    task automatic wrap_up();
        error_cnt += i_seq.timeouts;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // cycle ceiling well above the roughly 1200 cycles the tests take
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        wr_en = 1'b0;
        wr_sel = 5'h00;
        wr_data = 32'h0;
        rd_sel = 5'h00;
        for (int i = 0; i < 32; i++) m[i] = 32'h0;
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check_all();
        for (int i = 0; i < 32; i++) wr(i[4:0], $random(seed), 1'b1);
        wr(5'h05, 32'h0000_0003, 1'b1);
        wr(5'h06, 32'h0000_0028, 1'b1);
        wr(5'h07, 32'habcd_0000, 1'b1);
        wr(5'h08, 32'h8000_0001, 1'b1);
        // pointers, zero divisor, negative shifts, bad index and codes
        run(acu_pkg::OP_COPY_IND, 5'h05, 1);
        run(acu_pkg::OP_COPY_IND, 5'h06, 1);
        run(acu_pkg::OP_SAVE_IND, 5'h05, 1);
        run(acu_pkg::OP_SAVE_IND, 5'h06, 1);
        run(acu_pkg::OP_DIV, 5'h07, 1);
        run(acu_pkg::OP_MOD, 5'h07, 1);
        run(acu_pkg::OP_SHR_A, 5'h08, 0);
        run(acu_pkg::OP_ABS, 5'h08, 0);
        run(acu_pkg::OP_CLR, 5'h0a, 1);
        run(acu_pkg::OP_INC, 5'h1e, 1);
        for (int c = 25; c < 32; c++) run(c[4:0], 5'h03, 1);
        // every defined code, random registers, back to back and with gaps
        repeat (4) begin
            for (int c = 0; c < 25; c++) begin
                run(c[4:0], 5'({$random(seed)} % N), {$random(seed)} % 3);
            end
        end
        // a write while a multiply runs must be dropped
        fork
            run(acu_pkg::OP_MUL_S, 5'h03, 1);
            begin
                repeat (5) @(posedge clk);
                #1;
                wr(5'h03, 32'hdead_beef, 1'b0);
            end
        join
        check_all();
        wrap_up();
    end
endmodule
`default_nettype wire

// file: verification/acu_seq_model.sv
// command sequencer model issuing calculation commands to the unit
// assumes one clock; each issue returns in the done cycle
`timescale 1ns/1ns
`default_nettype none
module acu_seq_model (
    input wire logic clk_i,
    input wire logic done_i,
    output logic start_o,
    output logic [4:0] op_o,
    output logic [4:0] sel_o
);
    int timeouts = 0;
    initial begin
        start_o = 1'b0;
        op_o = 5'h1f;
        sel_o = 5'h1f;
    end
    // gap idles model a slow sequencer; gap 0 issues in the done cycle
    task automatic issue(input logic [4:0] op, input logic [4:0] sel,
                         input int gap);
        int n;
        repeat (gap) begin
            @(posedge clk_i);
            #1;
        end
        start_o = 1'b1;
        op_o = op;
        sel_o = sel;
        @(posedge clk_i);
        #1;
        start_o = 1'b0;
        op_o = ~op; // released fields must not keep their value
        sel_o = ~sel;
        n = 0;
        // bounded wait so a lost done cannot hang the run
        while (done_i !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 60) timeouts++;
    endtask
endmodule
`default_nettype wire

// file: verification/acu_top_asserts.sv
// port assertions for the accumulator calculation unit
// bound into acu_top; sees only its ports, one clock domain
`timescale 1ns/1ns
`default_nettype none
module acu_top_asserts #(
    parameter int NUM_REGS = 32,
    parameter int IDX_W = 5
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic START_I,
    input wire logic [acu_pkg::OP_W-1:0] OP_I,
    input wire logic [IDX_W-1:0] SEL_I,
    input wire logic WR_EN_I,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire logic ERR_O,
    input wire logic [31:0] ACC_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic take;
    logic mul_op;
    logic div_op;
    // divides leave early on a zero divisor, so only multiplies are timed
    assign take = START_I && !BUSY_O;
    assign mul_op = OP_I == acu_pkg::OP_MUL_S || OP_I == acu_pkg::OP_MUL_U;
    assign div_op = OP_I == acu_pkg::OP_DIV || OP_I == acu_pkg::OP_MOD;

    chk_take_busy: assert property (take |=> BUSY_O)
        else $error("busy not raised after a taken command");
    chk_simple_done: assert property (take && !mul_op && !div_op
        |-> ##1 BUSY_O ##1 (DONE_O && !BUSY_O))
        else $error("short command did not finish on time");
    chk_mul_latency: assert property (take && mul_op
        |=> BUSY_O [*8] ##27 DONE_O)
        else $error("multiply did not finish on time");
    chk_done_pulse: assert property (DONE_O |=> !DONE_O)
        else $error("done longer than one cycle");
    chk_err_with_done: assert property (ERR_O |-> DONE_O)
        else $error("error flag without done");
    chk_done_cause: assert property (DONE_O |-> $past(BUSY_O) && !BUSY_O)
        else $error("done without a running command");
    chk_bad_code: assert property (take && OP_I > 5'h18
        |-> ##2 (DONE_O && ERR_O))
        else $error("undefined code not flagged");
    chk_clear_acc: assert property (take && OP_I == acu_pkg::OP_CLR
        && SEL_I == acu_pkg::ACC_IDX |-> ##3 ACC_O == 32'h0)
        else $error("accumulator not cleared");
    chk_acc_cause: assert property ($changed(ACC_O)
        |-> $past(DONE_O) || $past(WR_EN_I, 2))
        else $error("accumulator changed without a cause");
    chk_sel_range: assert property (take && SEL_I >= NUM_REGS
        && OP_I == acu_pkg::OP_INC |-> ##2 ERR_O)
        else $error("out of range register not flagged");

    cover property (take && mul_op);
    cover property (DONE_O && ERR_O);
    cover property (DONE_O && take);
endmodule
bind acu_top acu_top_asserts #(.NUM_REGS(NUM_REGS), .IDX_W(IDX_W)) i_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .START_I(START_I), .OP_I(OP_I),
    .SEL_I(SEL_I), .WR_EN_I(WR_EN_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .ERR_O(ERR_O), .ACC_O(ACC_O)
);
`default_nettype wire
